/* design/cdt_pkg.sv */
`default_nettype none

package cdt_pkg;

  // channel organisation: channel 2p is the upper, 2p+1 the lower of pair p
  localparam int NUM_CHAN = 4;
  localparam int NUM_PAIR = 2;

  // clock select codes
  localparam logic [2:0] CKS_STOP     = 3'h0;
  localparam logic [2:0] CKS_DIV8     = 3'h1;
  localparam logic [2:0] CKS_DIV64    = 3'h2;
  localparam logic [2:0] CKS_DIV8192  = 3'h3;
  localparam logic [2:0] CKS_CASCADE  = 3'h4;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;

  // counter clear select codes
  localparam logic [1:0] CLR_NONE    = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;

  // output actions, numerically ordered by priority
  localparam logic [1:0] OUT_NONE   = 2'h0;
  localparam logic [1:0] OUT_LOW    = 2'h1;
  localparam logic [1:0] OUT_HIGH   = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;

  // capture edge codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  // prescaler taps (system clock divided by 8, 64, 8192)
  localparam int          PRESC_WIDTH   = 13;
  localparam logic [12:0] PRESC_MASK8   = 13'h0007;
  localparam logic [12:0] PRESC_MASK64  = 13'h003f;
  localparam logic [12:0] PRESC_MASK8K  = 13'h1fff;
  localparam logic [12:0] PRESC_RESET   = 13'h0000;

  // reset values and limits
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX   = 8'hff;
  localparam logic [7:0] COR_RESET = 8'hff;
  localparam logic       PIN_RESET = 1'b0;

  typedef struct packed {
    logic [2:0] clockSelectField;
    logic [1:0] counterClearSelect;
    logic [1:0] bEdgeOrOutputSelect;
    logic [1:0] aOutputSelect;
    logic       captureEnableBit;
  } cdt_cfg_type;

  typedef struct packed {
    logic matchAFlag;
    logic matchBFlag;
    logic overflowFlag;
  } cdt_flags_type;

  typedef enum {MODE_SEPARATE, MODE_16BIT, MODE_CMCOUNT, MODE_CONFLICT} cdt_mode_type;

endpackage

`default_nettype wire

/* design/cdt_timer.sv */
`default_nettype none

module cdt_timer
  import cdt_pkg::*;
(
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // channel settings
  input  wire cdt_cfg_type   [3:0]      chanCfg,
  input  wire logic          [3:0][7:0] compareARegister,
  input  wire logic          [3:0][7:0] compareBWriteData,
  input  wire logic          [3:0]      compareBWrite,
  input  wire cdt_flags_type [3:0]      flagClear,
  // external pins
  input  wire logic          [3:0]      externalClockPin,
  input  wire logic          [1:0]      captureOrOutputPinIn,
  output logic               [1:0]      captureOrOutputPinOut,
  output logic               [1:0]      captureOrOutputPinOe,
  output logic               [1:0]      upperTimerOutputPin,
  // state
  output logic               [3:0][7:0] countRegister,
  output logic               [3:0][7:0] compareBCaptureRegister,
  output cdt_flags_type      [3:0]      statusFlags
);

  logic [PRESC_WIDTH-1:0] presc;
  logic [3:0]             extSync1;
  logic [3:0]             extSync2;
  logic [3:0]             extPrev;
  logic [1:0]             capSync1;
  logic [1:0]             capSync2;
  logic [1:0]             capPrev;
  logic [3:0]             chanTick;
  logic [3:0]             incr;
  logic [3:0]             clr;
  logic [3:0]             evA;
  logic [3:0]             evB;
  logic [3:0]             ovfEv;
  logic [1:0]             capEvt;
  logic [3:0]             capSet;
  logic [1:0]             mode16;
  cdt_mode_type           pairMode [2];

  // count pulse from the selected source
  function automatic logic sourceTick(input logic [2:0] sel, input logic [12:0] pre,
                                      input logic rise, input logic fall);
    case (sel)
      CKS_DIV8:     return (pre & PRESC_MASK8) == PRESC_MASK8;
      CKS_DIV64:    return (pre & PRESC_MASK64) == PRESC_MASK64;
      CKS_DIV8192:  return pre == PRESC_MASK8K;
      CKS_EXT_RISE: return rise;
      CKS_EXT_FALL: return fall;
      CKS_EXT_BOTH: return rise | fall;
      default:      return 1'b0;
    endcase
  endfunction

  // capture edge detection by edge code
  function automatic logic edgeHit(input logic [1:0] sel, input logic rise, input logic fall);
    case (sel)
      EDGE_RISE: return rise;
      EDGE_FALL: return fall;
      EDGE_BOTH: return rise | fall;
      default:   return 1'b0;
    endcase
  endfunction

  // clear request from the clear select and the channel events
  function automatic logic clearHit(input logic [1:0] sel, input logic a, input logic b,
                                    input logic cap);
    case (sel)
      CLR_MATCH_A: return a;
      CLR_MATCH_B: return b | cap;
      default:     return 1'b0;
    endcase
  endfunction

  // highest priority output action of the coinciding matches
  function automatic logic [1:0] pinAction(input logic a, input logic b,
                                           input logic [1:0] selA, input logic [1:0] selB);
    logic [1:0] actA;
    logic [1:0] actB;
    actA = a ? selA : OUT_NONE;
    actB = b ? selB : OUT_NONE;
    return (actA > actB) ? actA : actB;
  endfunction

  // pin level after an action
  function automatic logic pinNext(input logic level, input logic [1:0] act);
    case (act)
      OUT_LOW:    return 1'b0;
      OUT_HIGH:   return 1'b1;
      OUT_TOGGLE: return ~level;
      default:    return level;
    endcase
  endfunction

  // free running prescaler
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      presc <= PRESC_RESET;
    else
      presc <= presc + 13'h0001;
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      extSync1 <= 4'h0;
      extSync2 <= 4'h0;
      extPrev  <= 4'h0;
      capSync1 <= 2'h0;
      capSync2 <= 2'h0;
      capPrev  <= 2'h0;
    end
    else
    begin
      extSync1 <= externalClockPin;
      extSync2 <= extSync1;
      extPrev  <= extSync2;
      capSync1 <= captureOrOutputPinIn;
      capSync2 <= capSync1;
      capPrev  <= capSync2;
    end
  end

  // source ticks per channel
  always_comb
  begin
    for (int c = 0; c < NUM_CHAN; c++)
      chanTick[c] = sourceTick(chanCfg[c].clockSelectField, presc,
                               extSync2[c] & ~extPrev[c], ~extSync2[c] & extPrev[c]);
  end

  // per pair mode, count, match, overflow and clear decisions
  always_comb
  begin
    for (int p = 0; p < NUM_PAIR; p++)
    begin
      int   u, l;
      logic capOn;
      u = 2 * p;
      l = 2 * p + 1;
      capOn = chanCfg[l].captureEnableBit;
      case ({chanCfg[u].clockSelectField == CKS_CASCADE,
             chanCfg[l].clockSelectField == CKS_CASCADE})
        2'b10:   pairMode[p] = MODE_16BIT;
        2'b01:   pairMode[p] = MODE_CMCOUNT;
        2'b11:   pairMode[p] = MODE_CONFLICT;
        default: pairMode[p] = MODE_SEPARATE;
      endcase
      mode16[p] = pairMode[p] == MODE_16BIT;
      capEvt[p] = capOn & edgeHit(mode16[p] ? chanCfg[u].bEdgeOrOutputSelect
                                            : chanCfg[l].bEdgeOrOutputSelect,
                                  capSync2[p] & ~capPrev[p], ~capSync2[p] & capPrev[p]);
      capSet[u] = mode16[p] & capEvt[p];
      capSet[l] = capEvt[p];
      case (pairMode[p])
        MODE_16BIT:
        begin
          incr[l]  = chanTick[l];
          incr[u]  = chanTick[l] & (countRegister[l] == CNT_MAX);
          evA[u]   = chanTick[l] & ({countRegister[u], countRegister[l]} ==
                                    {compareARegister[u], compareARegister[l]});
          evB[u]   = chanTick[l] & ~capOn & ({countRegister[u], countRegister[l]} ==
                                    {compareBCaptureRegister[u], compareBCaptureRegister[l]});
          evA[l]   = chanTick[l] & (countRegister[l] == compareARegister[l]);
          evB[l]   = chanTick[l] & ~capOn &
                     (countRegister[l] == compareBCaptureRegister[l]);
          ovfEv[u] = incr[u] & (countRegister[u] == CNT_MAX);
          ovfEv[l] = incr[l] & (countRegister[l] == CNT_MAX);
        end
        MODE_SEPARATE, MODE_CMCOUNT:
        begin
          incr[u]  = chanTick[u];
          evA[u]   = incr[u] & (countRegister[u] == compareARegister[u]);
          evB[u]   = incr[u] & (countRegister[u] == compareBCaptureRegister[u]);
          incr[l]  = (pairMode[p] == MODE_CMCOUNT) ? evA[u] : chanTick[l];
          evA[l]   = incr[l] & (countRegister[l] == compareARegister[l]);
          evB[l]   = incr[l] & ~capOn &
                     (countRegister[l] == compareBCaptureRegister[l]);
          ovfEv[u] = incr[u] & (countRegister[u] == CNT_MAX);
          ovfEv[l] = incr[l] & (countRegister[l] == CNT_MAX);
        end
        default:
        begin
          incr[u]  = 1'b0;
          incr[l]  = 1'b0;
          evA[u]   = 1'b0;
          evB[u]   = 1'b0;
          evA[l]   = 1'b0;
          evB[l]   = 1'b0;
          ovfEv[u] = 1'b0;
          ovfEv[l] = 1'b0;
        end
      endcase
      clr[u] = clearHit(chanCfg[u].counterClearSelect, evA[u], evB[u],
                        mode16[p] & capEvt[p]);
      clr[l] = mode16[p] ? clr[u]
                         : clearHit(chanCfg[l].counterClearSelect, evA[l], evB[l],
                                    capEvt[p]);
    end
  end

  // counters: clear wins over increment; no wrap flag when cleared
  always_ff @(posedge ref_clk)
  begin
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      if (rst)
        countRegister[c] <= CNT_RESET;
      else if (clr[c])
        countRegister[c] <= CNT_RESET;
      else if (incr[c])
        countRegister[c] <= countRegister[c] + 8'h01;
    end
  end

  // B registers: capture wins over a software load
  always_ff @(posedge ref_clk)
  begin
    for (int p = 0; p < NUM_PAIR; p++)
    begin
      if (rst)
      begin
        compareBCaptureRegister[2*p]   <= COR_RESET;
        compareBCaptureRegister[2*p+1] <= COR_RESET;
      end
      else
      begin
        if (capEvt[p] && mode16[p])
          compareBCaptureRegister[2*p] <= countRegister[2*p];
        else if (compareBWrite[2*p])
          compareBCaptureRegister[2*p] <= compareBWriteData[2*p];
        if (capEvt[p])
          compareBCaptureRegister[2*p+1] <= countRegister[2*p+1];
        else if (compareBWrite[2*p+1])
          compareBCaptureRegister[2*p+1] <= compareBWriteData[2*p+1];
      end
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk)
  begin
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      if (rst)
        statusFlags[c] <= '0;
      else
      begin
        statusFlags[c].matchAFlag   <= evA[c] |
                                       (statusFlags[c].matchAFlag & ~flagClear[c].matchAFlag);
        statusFlags[c].matchBFlag   <= evB[c] | capSet[c] |
                                       (statusFlags[c].matchBFlag & ~flagClear[c].matchBFlag);
        statusFlags[c].overflowFlag <= (ovfEv[c] & ~clr[c]) |
                                       (statusFlags[c].overflowFlag &
                                        ~flagClear[c].overflowFlag);
      end
    end
  end

  // timer output pins under each channel's own output select bits
  always_ff @(posedge ref_clk)
  begin
    for (int p = 0; p < NUM_PAIR; p++)
    begin
      if (rst)
      begin
        upperTimerOutputPin[p]   <= PIN_RESET;
        captureOrOutputPinOut[p] <= PIN_RESET;
        captureOrOutputPinOe[p]  <= 1'b0;
      end
      else
      begin
        upperTimerOutputPin[p]   <= pinNext(upperTimerOutputPin[p],
                                      pinAction(evA[2*p], evB[2*p],
                                                chanCfg[2*p].aOutputSelect,
                                                chanCfg[2*p].bEdgeOrOutputSelect));
        captureOrOutputPinOut[p] <= pinNext(captureOrOutputPinOut[p],
                                      pinAction(evA[2*p+1], evB[2*p+1],
                                                chanCfg[2*p+1].aOutputSelect,
                                                chanCfg[2*p+1].bEdgeOrOutputSelect));
        captureOrOutputPinOe[p]  <= ~chanCfg[2*p+1].captureEnableBit &
                                    ((chanCfg[2*p+1].aOutputSelect != OUT_NONE) |
                                     (chanCfg[2*p+1].bEdgeOrOutputSelect != OUT_NONE));
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_match_on_leave: assert property ($rose(statusFlags[1].matchAFlag) |->
      $past(countRegister[1]) == $past(compareARegister[1]) &&
      $past(incr[1]))
    else $error("match flag set without a count pulse at the match value");

  a_capture_copy: assert property (capEvt[0] && !mode16[0] |=>
      compareBCaptureRegister[1] == $past(countRegister[1]) && statusFlags[1].matchBFlag)
    else $error("capture did not load B and set its flag");

  a_wrap_overflow: assert property (pairMode[0] == MODE_SEPARATE && incr[0] &&
      countRegister[0] == CNT_MAX && !clr[0] |=>
      countRegister[0] == CNT_RESET && statusFlags[0].overflowFlag)
    else $error("8-bit wrap did not set overflow");

  a_carry_high: assert property (mode16[0] && incr[1] && countRegister[1] == 8'hff &&
      !clr[0] |=> countRegister[0] == $past(countRegister[0]) + 8'h01)
    else $error("high byte missed the carry");

  a_wide_overflow: assert property (mode16[0] && incr[1] && !clr[0] &&
      {countRegister[0], countRegister[1]} == 16'hffff |=>
      statusFlags[0].overflowFlag && statusFlags[1].overflowFlag)
    else $error("16-bit wrap did not set both overflow flags");

  a_event_count: assert property (pairMode[1] == MODE_CMCOUNT && evA[2] && !clr[3] |=>
      countRegister[3] == $past(countRegister[3]) + 8'h01)
    else $error("lower channel missed an upper match A event");

  a_conflict_stop: assert property (pairMode[1] == MODE_CONFLICT && !clr[2] && !clr[3] |=>
      countRegister[2] == $past(countRegister[2]) && countRegister[3] == $past(countRegister[3]))
    else $error("counters advanced with both cascade modes set");

  a_joint_clear: assert property (mode16[0] && clr[0] |=>
      countRegister[0] == 8'h00 && countRegister[1] == 8'h00)
    else $error("16-bit clear left a byte uncleared");

  a_wide_capture: assert property (mode16[0] && capEvt[0] |=>
      compareBCaptureRegister[0] == $past(countRegister[0]) &&
      compareBCaptureRegister[1] == $past(countRegister[1]) &&
      statusFlags[0].matchBFlag && statusFlags[1].matchBFlag)
    else $error("16-bit capture incomplete");

  a_toggle_priority: assert property (evA[0] && evB[0] &&
      chanCfg[0].aOutputSelect == OUT_LOW && chanCfg[0].bEdgeOrOutputSelect == OUT_TOGGLE |=>
      upperTimerOutputPin[0] == !$past(upperTimerOutputPin[0]))
    else $error("toggle did not win over drive-low");

endmodule // cdt_timer

`default_nettype wire

/* verification/cdt_pin_model.sv */
`default_nettype none

module cdt_pin_model
(
  // clock
  input  wire logic       ref_clk,
  // pins driven toward the timer
  output var  logic [3:0] extClk,
  output var  logic [1:0] capLevel
);
  timeunit 1ns;
  timeprecision 100ps;

  // pins rest low until a task moves them
  initial
  begin
    extClk = '0;
    capLevel = '0;
  end

  // n count pulses, w cycles high and w+1 low, then time for the synchroniser
  task automatic pulse(input int ch, input int n, input int w);
    repeat (n)
    begin
      @(posedge ref_clk);
      extClk[ch] <= 1'b1;
      repeat (w) @(posedge ref_clk);
      extClk[ch] <= 1'b0;
      repeat (w) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // move a capture pin and wait past its synchroniser
  task automatic capture(input int p, input logic v);
    @(posedge ref_clk);
    capLevel[p] <= v;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

endmodule // cdt_pin_model

`default_nettype wire

/* verification/tb_top.sv */
`default_nettype none

module tb_top
  import cdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // stimulus
  logic                     ref_clk = 1'b0;
  logic                     rst = 1'b1;
  cdt_cfg_type   [3:0]      chanCfg = '0;
  logic          [3:0][7:0] compareARegister = '0;
  logic          [3:0][7:0] compareBWriteData = '0;
  logic          [3:0]      compareBWrite = '0;
  cdt_flags_type [3:0]      flagClear = '0;
  // pins and observed state
  wire logic          [3:0]      extClk;
  wire logic          [1:0]      capLevel, capLine, pinOut, pinOe, upperPin;
  wire logic          [3:0][7:0] cnt, bReg;
  wire cdt_flags_type [3:0]      flags;
  int                            miscompares = 0;
  int                            totalChecks = 0;
  logic               [7:0]      n;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // capture pin level: the timer when it drives, the model otherwise
  assign capLine = (pinOe & pinOut) | (~pinOe & capLevel);

  cdt_timer u_cdt_timer (
    .ref_clk(ref_clk), .rst(rst), .chanCfg(chanCfg), .compareARegister(compareARegister),
    .compareBWriteData(compareBWriteData), .compareBWrite(compareBWrite),
    .flagClear(flagClear), .externalClockPin(extClk), .captureOrOutputPinIn(capLine),
    .captureOrOutputPinOut(pinOut), .captureOrOutputPinOe(pinOe),
    .upperTimerOutputPin(upperPin), .countRegister(cnt),
    .compareBCaptureRegister(bReg), .statusFlags(flags)
  );

  cdt_pin_model u_cdt_pin_model (.ref_clk(ref_clk), .extClk(extClk), .capLevel(capLevel));

  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic completeRun();
    $display("checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic cdt_cfg_type mk(input logic [2:0] c, input logic [1:0] k,
                                     input logic [1:0] b, input logic [1:0] a, input logic i);
    mk = {c, k, b, a, i};
  endfunction

  // reset with all settings cleared
  task automatic doReset(input int cycles);
    @(posedge ref_clk);
    rst <= 1'b1;
    chanCfg <= '0;
    compareARegister <= '0;
    repeat (cycles) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic setup(input int ch, input cdt_cfg_type c, input logic [7:0] a);
    @(posedge ref_clk);
    chanCfg[ch] <= c;
    compareARegister[ch] <= a;
  endtask

  task automatic writeB(input int ch, input logic [7:0] v);
    @(posedge ref_clk);
    compareBWriteData[ch] <= v;
    compareBWrite[ch] <= 1'b1;
    @(posedge ref_clk);
    compareBWrite <= '0;
  endtask

  task automatic clearFlags();
    @(posedge ref_clk);
    flagClear <= '1;
    @(posedge ref_clk);
    flagClear <= '0;
    @(negedge ref_clk);
  endtask

  // cut a hang short
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    completeRun();
  end

  // test sequence
  initial
  begin
    doReset(16);
    for (int c = 0; c < 4; c++)
    begin
      check(cnt[c], 16'(CNT_RESET));
      check(bReg[c], 16'(COR_RESET));
      check(16'(flags[c]), 16'h0000);
    end
    // 8-bit match timing and overflow
    setup(0, mk(CKS_EXT_RISE, CLR_NONE, OUT_NONE, OUT_NONE, 1'b0), 8'h02);
    u_cdt_pin_model.pulse(0, 2, 2);
    check(flags[0].matchAFlag, 1'b0);
    u_cdt_pin_model.pulse(0, 1, 5);
    check(flags[0].matchAFlag, 1'b1);
    u_cdt_pin_model.pulse(0, 252, 3);
    check(cnt[0], 16'h00ff);
    check(flags[0].overflowFlag, 1'b0);
    u_cdt_pin_model.pulse(0, 1, 3);
    check(cnt[0], 16'h0000);
    check(flags[0].overflowFlag, 1'b1);
    // simultaneous A and B matches on the upper pin
    doReset(2);
    setup(0, mk(CKS_EXT_RISE, CLR_NONE, OUT_TOGGLE, OUT_LOW, 1'b0), 8'h01);
    writeB(0, 8'h01);
    u_cdt_pin_model.pulse(0, 2, 3);
    check(upperPin[0], 1'b1);
    check(flags[0].matchBFlag, 1'b1);
    // 8-bit capture for every edge code
    doReset(2);
    n = 8'h00;
    for (int e = 0; e < 3; e++)
    begin
      setup(1, mk(CKS_EXT_RISE, CLR_NONE, 2'(e), OUT_NONE, 1'b1), 8'h80);
      u_cdt_pin_model.pulse(1, 1, 3);
      n++;
      clearFlags();
      u_cdt_pin_model.capture(0, 1'b1);
      check(flags[1].matchBFlag, 1'(e != 1));
      if (e != 1) check(bReg[1], 16'(n));
      u_cdt_pin_model.pulse(1, 1, 3);
      n++;
      clearFlags();
      u_cdt_pin_model.capture(0, 1'b0);
      check(flags[1].matchBFlag, 1'(e != 0));
      if (e != 0) check(bReg[1], 16'(n));
    end
    // 16-bit count mode: matches, carry and low overflow
    doReset(2);
    setup(0, mk(CKS_CASCADE, CLR_NONE, OUT_NONE, OUT_NONE, 1'b0), 8'h01);
    setup(1, mk(CKS_EXT_RISE, CLR_NONE, OUT_NONE, OUT_NONE, 1'b0), 8'h05);
    u_cdt_pin_model.pulse(1, 6, 2);
    check({cnt[0], cnt[1]}, 16'h0006);
    check({flags[0].matchAFlag, flags[1].matchAFlag}, 16'h1);
    clearFlags();
    u_cdt_pin_model.pulse(1, 250, 2);
    check({cnt[0], cnt[1]}, 16'h0100);
    check({flags[0].overflowFlag, flags[1].overflowFlag}, 16'h1);
    u_cdt_pin_model.pulse(1, 6, 2);
    check({flags[0].matchAFlag, flags[1].matchAFlag}, 16'h3);
    // 16-bit clear by upper select only, pins per channel
    doReset(2);
    setup(0, mk(CKS_CASCADE, CLR_MATCH_A, OUT_NONE, OUT_TOGGLE, 1'b0), 8'h00);
    setup(1, mk(CKS_EXT_RISE, CLR_MATCH_B, OUT_NONE, OUT_HIGH, 1'b0), 8'h03);
    writeB(1, 8'h01);
    u_cdt_pin_model.pulse(1, 2, 3);
    check({cnt[0], cnt[1]}, 16'h0002);
    u_cdt_pin_model.pulse(1, 2, 3);
    check({cnt[0], cnt[1]}, 16'h0000);
    check({upperPin[0], pinOut[0], pinOe[0]}, 16'h7);
    // 16-bit capture, edge taken from the upper channel
    doReset(2);
    setup(0, mk(CKS_CASCADE, CLR_NONE, EDGE_RISE, OUT_NONE, 1'b0), 8'h80);
    setup(1, mk(CKS_EXT_RISE, CLR_NONE, EDGE_FALL, OUT_NONE, 1'b1), 8'h80);
    u_cdt_pin_model.pulse(1, 3, 3);
    u_cdt_pin_model.capture(0, 1'b1);
    check({bReg[0], bReg[1]}, 16'h0003);
    check({flags[0].matchBFlag, flags[1].matchBFlag}, 16'h3);
    clearFlags();
    u_cdt_pin_model.capture(0, 1'b0);
    check({flags[0].matchBFlag, flags[1].matchBFlag}, 16'h0);
    // second pair: compare match count mode
    doReset(2);
    setup(2, mk(CKS_EXT_RISE, CLR_MATCH_A, OUT_NONE, OUT_TOGGLE, 1'b0), 8'h02);
    setup(3, mk(CKS_CASCADE, CLR_NONE, OUT_NONE, OUT_NONE, 1'b0), 8'h10);
    u_cdt_pin_model.pulse(2, 9, 3);
    check({cnt[2], cnt[3]}, 16'h0003);
    check({upperPin[1], flags[2].matchAFlag, flags[3].matchAFlag}, 16'h6);
    // both cascade codes in one pair stop the counters
    setup(2, mk(CKS_CASCADE, CLR_MATCH_A, OUT_NONE, OUT_TOGGLE, 1'b0), 8'h02);
    u_cdt_pin_model.pulse(2, 3, 3);
    check({cnt[2], cnt[3]}, 16'h0003);
    completeRun();
  end

endmodule // tb_top

`default_nettype wire
